// >>> pkg/uart_pkg.sv
package uart_pkg;

  typedef enum logic [1:0] {
    MODE_SHIFT     = 2'b00,
    MODE_UART8     = 2'b01,
    MODE_UART9_FIX = 2'b10,
    MODE_UART9_VAR = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10
  } rx_state_t;

  // Byte offsets on the register bus.
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_DATA    = 5'h04;
  localparam logic [4:0] OFS_STATUS  = 5'h08;
  localparam logic [4:0] OFS_POWER   = 5'h0c;
  localparam logic [4:0] OFS_BRG_LO  = 5'h10;
  localparam logic [4:0] OFS_BRG_HI  = 5'h14;
  localparam logic [4:0] OFS_BRG_SEL = 5'h18;

  // Field positions.
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_ADDR_EN = 5;
  localparam int CTL_RX_EN   = 4;
  localparam int CTL_TX_B8   = 3;
  localparam int CTL_RX_B8   = 2;
  localparam int CTL_TI      = 1;
  localparam int CTL_RI      = 0;
  localparam int STAT_DBUF   = 7;
  localparam int STAT_BRST   = 6;
  localparam int STAT_FE     = 3;
  localparam int STAT_BRK    = 2;
  localparam int PWR_DOUBLE  = 7;
  localparam int PWR_FE_VIEW = 6;
  localparam int BRG_SEL_BIT = 0;

  // Counts.
  localparam int DATA_BITS  = 8;
  localparam int OS_PER_BIT = 16;
  localparam int BREAK_BITS = 11;
  localparam logic [3:0] OS_LAST      = 4'(OS_PER_BIT - 1);
  localparam logic [3:0] OS_MID       = 4'(OS_PER_BIT / 2 - 1);
  localparam logic [3:0] M0_CLK_HIGH  = 4'(OS_PER_BIT / 2);
  localparam logic [3:0] M0_IDX_LAST  = 4'(DATA_BITS - 1);
  localparam logic [3:0] TX_IDX_LAST8 = 4'(DATA_BITS + 1);
  localparam logic [3:0] TX_IDX_LAST9 = 4'(DATA_BITS + 2);
  localparam logic [3:0] RX_STOP8     = 4'(DATA_BITS);
  localparam logic [3:0] RX_STOP9     = 4'(DATA_BITS + 1);
  localparam logic [7:0] BREAK_LAST   = 8'(BREAK_BITS * OS_PER_BIT);

  typedef struct packed {
    logic       mode_sel_hi;
    logic       mode_sel_lo;
    logic       addr_en;
    logic       rx_en;
    logic       tx_ninth_bit;
    logic       baud_double_sel;
    logic       frame_err_view_sel;
    logic       dbuf_enable;
    logic       brk_rst_en;
    logic       brg_sel;
    logic [7:0] brg_divisor_lo;
    logic [7:0] brg_divisor_hi;
  } ctl_t;

  typedef struct packed {
    logic        busy;
    logic        m0_rx;
    logic [10:0] frame;
    logic [3:0]  idx;
    logic [3:0]  os;
    logic [7:0]  hold;
    logic        hold_b8;
    logic        hold_full;
    logic        ti;
    logic        txd;
    logic        rxd_out;
    logic        rxd_oe_n;
  } tx_t;

  typedef struct packed {
    rx_state_t  state;
    logic [3:0] os;
    logic [3:0] idx;
    logic [8:0] sh;
    logic [7:0] data;
    logic       rx_ninth_bit;
    logic       ri;
    logic       fe;
    logic       brk;
    logic [7:0] brk_cnt;
    logic       boot_req;
  } rx_t;

  // Values after reset.
  localparam ctl_t       CTL_RESET  = '0;
  localparam tx_t        TX_RESET   = '{txd: 1'b1, rxd_out: 1'b1, rxd_oe_n: 1'b1, default: '0};
  localparam rx_t        RX_RESET   = '0;
  localparam logic [2:0] SYNC_RESET = 3'h7;

endpackage

// >>> verilog/enhanced_uart_with_brg.sv
`timescale 1ns/100ps
// Behaviour
// R1 - Shift-register mode: data on rxd pin, shift clock on txd, 8 bits LSB first.
// R2 - Shift-register mode bit rate is fixed at CPU clock divided by sixteen.
// R3 - 8-bit mode frame: start 0, eight data bits LSB first, stop 1.
// R4 - 8-bit mode receive stores the stop bit into rx_ninth_bit.
// R5 - 8-bit mode rate comes from Timer 1 overflow or the baud rate generator.
// R6 - 9-bit mode frame: start, eight data bits, tx_ninth_bit, stop 1.
// R7 - 9-bit mode receive stores the ninth bit into rx_ninth_bit, drops stop.
// R8 - Fixed 9-bit mode rate is clock/16 with baud_double_sel, else clock/32.
// R9 - Variable 9-bit mode equals fixed mode except rate source.
// R10 - Baud generator divisor is brg_divisor_hi and brg_divisor_lo concatenated.
// R11 - Timer 1 overflow is halved again when baud_double_sel is set.
// R12 - Baud generator runs from the oscillator clock.
// R13 - Framing error always in status; also at control bit 7 when view selected.
// R14 - Software sets mode bits while frame_err_view_sel is zero.
// R15 - Break flagged when the receive line is low for eleven bit times.
// R16 - A detected break can request device reset into the loader.
// R17 - Double buffering accepts the next character during shifting, back to back.
// R18 - With dbuf_enable clear the transmitter is single buffered.
// R19 - Software keeps dbuf_enable clear in shift-register mode.
// R20 - With double buffering the transmit flag rises when the holding buffer empties.
// R21 - Single buffered: tx_ninth_bit must stay stable until the transmit flag.
// R22 - Double buffered: tx_ninth_bit is captured with the data byte on write.
module enhanced_uart_with_brg
  import uart_pkg::*;
(
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // Register bus
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output      logic [31:0] o_avs_readdata,
  output      logic        o_avs_waitrequest,
  // Rate source
  input  wire logic        i_timer1_ovf,
  // Serial pins
  input  wire logic        i_rxd_in,
  output      logic        o_rxd_out,
  output      logic        o_rxd_oe_n,
  output      logic        o_txd,
  // System
  output      logic        o_ti,
  output      logic        o_ri,
  output      logic        o_break_boot_req
);

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
    return addr[4:2] == ofs[4:2];
  endfunction

  function automatic logic [10:0] frame_of(input logic [7:0] d, input logic b8, input logic nine);
    return {1'b1, (nine ? b8 : 1'b1), d, 1'b0};
  endfunction

  ctl_t        ctl_reg, ctl_next;
  tx_t         tx_reg, tx_next;
  rx_t         rx_reg, rx_next;
  logic [2:0]  sync_reg, sync_next;
  logic        rxd_f_reg, rxd_f_next;
  logic [15:0] brg_cnt_reg, brg_cnt_next;
  logic        half_reg, half_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        os_tick;
  logic        m0_done;
  logic        rx_done;
  logic        load_hold;
  logic        bus_wr;
  logic        wr_ctl;
  logic        wr_data;
  logic        wr_stat;
  logic [7:0]  wd;
  logic [7:0]  rd_mux;
  logic [3:0]  tx_last;
  logic [3:0]  rx_stop;
  logic        framed;
  logic        nine;
  logic        tx_bit;
  mode_t       mode;

  assign mode    = mode_t'({ctl_reg.mode_sel_hi, ctl_reg.mode_sel_lo});
  assign framed  = mode != MODE_SHIFT;
  assign nine    = ctl_reg.mode_sel_hi;
  assign tx_last = (mode == MODE_SHIFT) ? M0_IDX_LAST : (nine ? TX_IDX_LAST9 : TX_IDX_LAST8);
  assign rx_stop = nine ? RX_STOP9 : RX_STOP8;

  // Register bus: one wait state, so the read mux has a full cycle to settle.
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
  assign o_avs_readdata    = rdata_reg;
  assign bus_wr  = i_avs_write & ack_reg & i_avs_byteenable[0];
  assign wr_ctl  = bus_wr & hit(i_avs_address, OFS_CONTROL);
  assign wr_data = bus_wr & hit(i_avs_address, OFS_DATA);
  assign wr_stat = bus_wr & hit(i_avs_address, OFS_STATUS);
  assign wd      = i_avs_writedata[7:0];

  always_comb
  begin
    rd_mux = 8'h00;
    if (hit(i_avs_address, OFS_CONTROL))
    begin
      rd_mux = {(ctl_reg.frame_err_view_sel ? rx_reg.fe : ctl_reg.mode_sel_hi), ctl_reg.mode_sel_lo, // R13
                ctl_reg.addr_en, ctl_reg.rx_en, ctl_reg.tx_ninth_bit, rx_reg.rx_ninth_bit, tx_reg.ti, rx_reg.ri};
    end
    else if (hit(i_avs_address, OFS_DATA))
    begin
      rd_mux = rx_reg.data;
    end
    else if (hit(i_avs_address, OFS_STATUS))
    begin
      rd_mux = {ctl_reg.dbuf_enable, ctl_reg.brk_rst_en, 2'b00, rx_reg.fe, rx_reg.brk, // R13 R15
                tx_reg.busy, tx_reg.hold_full};
    end
    else if (hit(i_avs_address, OFS_POWER))
    begin
      rd_mux = {ctl_reg.baud_double_sel, ctl_reg.frame_err_view_sel, 6'h00};
    end
    else if (hit(i_avs_address, OFS_BRG_LO))
    begin
      rd_mux = ctl_reg.brg_divisor_lo;
    end
    else if (hit(i_avs_address, OFS_BRG_HI))
    begin
      rd_mux = ctl_reg.brg_divisor_hi;
    end
    else if (hit(i_avs_address, OFS_BRG_SEL))
    begin
      rd_mux = {7'h00, ctl_reg.brg_sel};
    end
    ack_next   = (i_avs_read | i_avs_write) & ~ack_reg;
    rdata_next = rdata_reg;
    if (i_avs_read & ~ack_reg)
    begin
      rdata_next = {24'h000000, rd_mux};
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // Software-written control.
  always_comb
  begin
    ctl_next = ctl_reg;
    if (wr_ctl)
    begin
      if (!ctl_reg.frame_err_view_sel)
      begin
        ctl_next.mode_sel_hi = wd[CTL_MODE_HI]; // R14
      end
      ctl_next.mode_sel_lo  = wd[CTL_MODE_LO];
      ctl_next.addr_en      = wd[CTL_ADDR_EN];
      ctl_next.rx_en        = wd[CTL_RX_EN];
      ctl_next.tx_ninth_bit = wd[CTL_TX_B8];
    end
    if (wr_stat)
    begin
      ctl_next.dbuf_enable = wd[STAT_DBUF];
      ctl_next.brk_rst_en  = wd[STAT_BRST];
    end
    if (bus_wr & hit(i_avs_address, OFS_POWER))
    begin
      ctl_next.baud_double_sel    = wd[PWR_DOUBLE];
      ctl_next.frame_err_view_sel = wd[PWR_FE_VIEW];
    end
    if (bus_wr & hit(i_avs_address, OFS_BRG_LO))
    begin
      ctl_next.brg_divisor_lo = wd;
    end
    if (bus_wr & hit(i_avs_address, OFS_BRG_HI))
    begin
      ctl_next.brg_divisor_hi = wd;
    end
    if (bus_wr & hit(i_avs_address, OFS_BRG_SEL))
    begin
      ctl_next.brg_sel = wd[BRG_SEL_BIT];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      ctl_reg <= CTL_RESET;
    end
    else
    begin
      ctl_reg <= ctl_next;
    end
  end

  // Receive pin synchroniser with agreement filter.
  always_comb
  begin
    sync_next  = {sync_reg[1:0], i_rxd_in};
    rxd_f_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[1] : rxd_f_reg;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      sync_reg  <= SYNC_RESET;
      rxd_f_reg <= 1'b1;
    end
    else
    begin
      sync_reg  <= sync_next;
      rxd_f_reg <= rxd_f_next;
    end
  end

  // Oversample tick, sixteen per bit in the framed modes.
  // The oscillator clock and the CPU clock are the same clock in this block.
  always_comb
  begin
    os_tick      = 1'b0;
    brg_cnt_next = brg_cnt_reg;
    half_next    = half_reg;
    unique case (mode)
      MODE_SHIFT:
      begin
        half_next = 1'b0;
      end
      MODE_UART9_FIX:
      begin
        if (ctl_reg.baud_double_sel)
        begin
          os_tick = 1'b1; // R8
        end
        else
        begin
          half_next = ~half_reg;
          os_tick   = half_reg; // R8
        end
      end
      MODE_UART8, MODE_UART9_VAR:
      begin
        if (ctl_reg.brg_sel)
        begin
          if (brg_cnt_reg == 16'h0000)
          begin
            os_tick      = 1'b1; // R5 R9 R12
            brg_cnt_next = {ctl_reg.brg_divisor_hi, ctl_reg.brg_divisor_lo}; // R10
          end
          else
          begin
            brg_cnt_next = brg_cnt_reg - 16'h0001;
          end
        end
        else if (i_timer1_ovf)
        begin
          if (ctl_reg.baud_double_sel)
          begin
            half_next = ~half_reg;
            os_tick   = half_reg; // R11
          end
          else
          begin
            os_tick = 1'b1; // R5 R9
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      brg_cnt_reg <= 16'h0000;
      half_reg    <= 1'b0;
    end
    else
    begin
      brg_cnt_reg <= brg_cnt_next;
      half_reg    <= half_next;
    end
  end

  // Transmitter and shift-register engine.
  always_comb
  begin
    tx_next   = tx_reg;
    m0_done   = 1'b0;
    load_hold = 1'b0;
    if (wr_ctl)
    begin
      tx_next.ti = wd[CTL_TI];
    end
    if (tx_reg.busy)
    begin
      if (mode == MODE_SHIFT)
      begin
        tx_next.os = tx_reg.os + 4'h1; // R2
        if (tx_reg.m0_rx && tx_reg.os == OS_LAST)
        begin
          tx_next.frame[tx_reg.idx] = rxd_f_reg; // R1
        end
      end
      else if (os_tick)
      begin
        tx_next.os = tx_reg.os + 4'h1;
      end
      if (tx_reg.os == OS_LAST && (mode == MODE_SHIFT || os_tick))
      begin
        if (tx_reg.idx != tx_last)
        begin
          tx_next.idx = tx_reg.idx + 4'h1;
        end
        else
        begin
          tx_next.busy = 1'b0;
          if (mode == MODE_SHIFT && tx_reg.m0_rx)
          begin
            m0_done = 1'b1;
          end
          else if (!ctl_reg.dbuf_enable)
          begin
            tx_next.ti = 1'b1; // R18
          end
        end
      end
    end
    // Framed modes only: in shift mode the holding buffer is never used.
    if (ctl_reg.dbuf_enable && framed && tx_reg.hold_full && !tx_next.busy) // R19
    begin
      load_hold         = 1'b1;
      tx_next.busy      = 1'b1;
      tx_next.m0_rx     = 1'b0;
      tx_next.idx       = 4'h0;
      tx_next.os        = 4'h0;
      tx_next.frame     = frame_of(tx_reg.hold, tx_reg.hold_b8, nine); // R17
      tx_next.hold_full = 1'b0;
      tx_next.ti        = 1'b1; // R20
    end
    if (wr_data)
    begin
      if (ctl_reg.dbuf_enable && framed)
      begin
        tx_next.hold      = wd; // R17
        tx_next.hold_b8   = ctl_reg.tx_ninth_bit; // R22
        tx_next.hold_full = 1'b1;
      end
      else if (!tx_reg.busy)
      begin
        tx_next.busy  = 1'b1; // R18
        tx_next.m0_rx = 1'b0;
        tx_next.idx   = 4'h0;
        tx_next.os    = 4'h0;
        tx_next.frame = framed ? frame_of(wd, ctl_reg.tx_ninth_bit, nine) : {3'h7, wd}; // R3 R6
      end
    end
    if (mode == MODE_SHIFT && !tx_next.busy && ctl_reg.rx_en && !rx_reg.ri && !m0_done)
    begin
      tx_next.busy  = 1'b1; // R1
      tx_next.m0_rx = 1'b1;
      tx_next.idx   = 4'h0;
      tx_next.os    = 4'h0;
    end
    // Single buffered, the ninth bit is read live so software may set it after the data.
    tx_bit = tx_next.frame[tx_next.idx];
    if (!ctl_reg.dbuf_enable && nine && tx_next.idx == TX_IDX_LAST8)
    begin
      tx_bit = ctl_reg.tx_ninth_bit; // R21
    end
    tx_next.txd      = 1'b1;
    tx_next.rxd_out  = 1'b1;
    tx_next.rxd_oe_n = 1'b1;
    if (tx_next.busy)
    begin
      if (mode == MODE_SHIFT)
      begin
        tx_next.txd = tx_next.os >= M0_CLK_HIGH; // R1 R2
        if (!tx_next.m0_rx)
        begin
          tx_next.rxd_oe_n = 1'b0; // R1
          tx_next.rxd_out  = tx_next.frame[tx_next.idx];
        end
      end
      else
      begin
        tx_next.txd = tx_bit; // R3 R6
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      tx_reg <= TX_RESET;
    end
    else
    begin
      tx_reg <= tx_next;
    end
  end

  // Receiver, framing error and break detection. Hardware sets are applied after
  // software writes so that an event in the clearing cycle is kept.
  always_comb
  begin
    rx_next          = rx_reg;
    rx_next.boot_req = 1'b0;
    rx_done          = 1'b0;
    if (wr_ctl)
    begin
      rx_next.ri           = wd[CTL_RI];
      rx_next.rx_ninth_bit = wd[CTL_RX_B8];
      if (ctl_reg.frame_err_view_sel)
      begin
        rx_next.fe = rx_reg.fe & wd[CTL_MODE_HI]; // R13
      end
    end
    if (wr_stat)
    begin
      rx_next.fe  = rx_next.fe & wd[STAT_FE];
      rx_next.brk = rx_reg.brk & wd[STAT_BRK];
    end
    if (m0_done)
    begin
      rx_next.data = tx_next.frame[7:0]; // R1
      rx_next.ri   = 1'b1;
    end
    if (framed && ctl_reg.rx_en)
    begin
      unique case (rx_reg.state)
        RX_IDLE:
        begin
          if (os_tick && !rxd_f_reg)
          begin
            rx_next.state = RX_START;
            rx_next.os    = 4'h0;
          end
        end
        RX_START:
        begin
          if (os_tick)
          begin
            rx_next.os = rx_reg.os + 4'h1;
            if (rx_reg.os == OS_MID)
            begin
              rx_next.state = rxd_f_reg ? RX_IDLE : RX_BITS;
              rx_next.os    = 4'h0;
              rx_next.idx   = 4'h0;
            end
          end
        end
        RX_BITS:
        begin
          if (os_tick)
          begin
            rx_next.os = rx_reg.os + 4'h1;
            if (rx_reg.os == OS_LAST)
            begin
              if (rx_reg.idx != rx_stop)
              begin
                rx_next.sh[rx_reg.idx] = rxd_f_reg; // R3 R6
                rx_next.idx = rx_reg.idx + 4'h1;
              end
              else
              begin
                rx_next.state = RX_IDLE;
                rx_done       = 1'b1;
                if (!rxd_f_reg)
                begin
                  rx_next.fe = 1'b1; // R13
                end
                if (!rx_reg.ri || !rx_next.ri)
                begin
                  rx_next.data         = rx_reg.sh[7:0];
                  rx_next.rx_ninth_bit = nine ? rx_reg.sh[8] : rxd_f_reg; // R4 R7
                  rx_next.ri           = 1'b1;
                end
              end
            end
          end
        end
        default:
        begin
          rx_next.state = RX_IDLE;
        end
      endcase
    end
    else
    begin
      rx_next.state = RX_IDLE;
    end
    if (framed && os_tick)
    begin
      if (rxd_f_reg)
      begin
        rx_next.brk_cnt = 8'h00;
      end
      else if (rx_reg.brk_cnt != BREAK_LAST)
      begin
        rx_next.brk_cnt = rx_reg.brk_cnt + 8'h01;
        if (rx_reg.brk_cnt == BREAK_LAST - 8'h01)
        begin
          rx_next.brk      = 1'b1; // R15
          rx_next.boot_req = ctl_reg.brk_rst_en; // R16
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      rx_reg <= RX_RESET;
    end
    else
    begin
      rx_reg <= rx_next;
    end
  end

  assign o_txd            = tx_reg.txd;
  assign o_rxd_out        = tx_reg.rxd_out;
  assign o_rxd_oe_n       = tx_reg.rxd_oe_n;
  assign o_ti             = tx_reg.ti;
  assign o_ri             = rx_reg.ri;
  assign o_break_boot_req = rx_reg.boot_req;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  a_m0_bit_period: assert property ((mode == MODE_SHIFT) && tx_reg.busy && tx_reg.os == 4'h0 // R2
    && tx_reg.idx == 4'h0 && $stable(mode) |-> ##15 (tx_reg.os == OS_LAST || mode != MODE_SHIFT))
    else $error("Shift mode bit is not sixteen clocks.");
  a_start_bit_low: assert property (tx_reg.busy && framed && tx_reg.idx == 4'h0 |-> !o_txd) // R3
    else $error("Start bit is not low.");
  a_stop_bit_high: assert property (tx_reg.busy && framed && tx_reg.idx == tx_last |-> o_txd) // R6
    else $error("Stop bit is not high.");
  a_stop_to_ninth: assert property (rx_done && !nine && !rx_reg.ri |=> rx_reg.rx_ninth_bit == $past(rxd_f_reg)) // R4
    else $error("Stop bit not stored in receive ninth bit.");
  a_ninth_stored: assert property (rx_done && nine && !rx_reg.ri |=> rx_reg.rx_ninth_bit == $past(rx_reg.sh[8])) // R7
    else $error("Ninth data bit not stored.");
  a_fix_rate_half: assert property (mode == MODE_UART9_FIX && !ctl_reg.baud_double_sel && os_tick // R8
    |=> !os_tick || mode != MODE_UART9_FIX || ctl_reg.baud_double_sel)
    else $error("Fixed rate tick not halved.");
  a_t1_halved: assert property (framed && mode != MODE_UART9_FIX && !ctl_reg.brg_sel // R11
    && ctl_reg.baud_double_sel && !half_reg |-> !os_tick)
    else $error("Timer overflow not halved.");
  a_fe_view_read: assert property (i_avs_read && !ack_reg && hit(i_avs_address, OFS_CONTROL) // R13
    && ctl_reg.frame_err_view_sel |=> o_avs_readdata[7] == $past(rx_reg.fe))
    else $error("Framing error not shown at control bit 7.");
  a_break_flag: assert property (framed && os_tick && !rxd_f_reg && rx_reg.brk_cnt == BREAK_LAST - 8'h01 // R15
    |=> rx_reg.brk && (o_break_boot_req == $past(ctl_reg.brk_rst_en)))
    else $error("Break not flagged after eleven low bits.");
  a_dbuf_ti: assert property (load_hold |=> tx_reg.ti && tx_reg.busy && (!tx_reg.hold_full || $past(wr_data))) // R20
    else $error("Transmit flag not raised on buffer empty.");
  a_single_buf: assert property (wr_data && !ctl_reg.dbuf_enable && framed && !tx_reg.busy // R18
    |=> tx_reg.busy && tx_reg.frame[8:1] == $past(wd))
    else $error("Single buffered write did not start a frame.");
  a_hold_b8: assert property (wr_data && ctl_reg.dbuf_enable && framed // R22
    |=> tx_reg.hold_b8 == $past(ctl_reg.tx_ninth_bit) || !tx_reg.hold_full)
    else $error("Ninth bit not captured with data.");

endmodule

// >>> testbench/uart_line_peer.sv
`timescale 1ns/100ps
module uart_line_peer (
  // Clock and line
  input  wire logic i_clk,
  input  wire logic i_txd,
  input  var int    i_bit_clks,
  input  var int    i_nbits,
  output      logic o_rxd
);
  logic [10:0] rx_q[$];
  int          t_q[$];
  logic [10:0] fr;
  initial o_rxd = 1'b1;
  // Each bit is sampled in its middle, so a single stop bit still leaves time to catch the next start.
  always
  begin
    @(negedge i_txd);
    t_q.push_back(int'($time));
    fr = '0;
    repeat (i_bit_clks / 2) @(posedge i_clk);
    for (int i = 0; i < i_nbits; i++)
    begin
      fr[i] = i_txd;
      if (i < i_nbits - 1)
        repeat (i_bit_clks) @(posedge i_clk);
    end
    rx_q.push_back(fr);
  end
  task automatic send(input int n, input logic [10:0] f);
    for (int i = 0; i < n; i++)
    begin
      o_rxd <= f[i];
      repeat (i_bit_clks) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
  endtask
endmodule

// >>> testbench/enhanced_uart_with_brg_tb.sv
`timescale 1ns/100ps
module enhanced_uart_with_brg_tb
  import uart_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  addr = '0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic        wait_req, rxd, rxd_out, rxd_oe_n, txd, ti, ri, boot;
  logic        boot_seen = 1'b0;
  logic        t1 = 1'b0;
  logic [7:0]  shreg = '0;
  logic [7:0]  q;
  int          bit_clks = 16;
  int          nbits = 11;
  int          failures = 0;
  int          cmp_count = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (boot === 1'b1) boot_seen <= 1'b1;
  always @(posedge txd) shreg <= {rxd_out, shreg[7:1]};

  enhanced_uart_with_brg u_enhanced_uart_with_brg (
    .i_sys_clk(clk), .i_reset(rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'h1), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_timer1_ovf(t1), .i_rxd_in(rxd), .o_rxd_out(rxd_out),
    .o_rxd_oe_n(rxd_oe_n), .o_txd(txd), .o_ti(ti), .o_ri(ri), .o_break_boot_req(boot));
  uart_line_peer u_uart_line_peer (
    .i_clk(clk), .i_txd(txd), .i_bit_clks(bit_clks), .i_nbits(nbits), .o_rxd(rxd));

  task automatic report_and_stop();
    $display("Comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [10:0] e, input logic [10:0] g, input string s);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // The request stays up until waitrequest is seen low at a rising edge.
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_req !== 1'b0 && n < 50);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic w8(input logic [4:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e, input string s);
    acc(1'b0, a, 8'h00);
    chk({3'h0, e}, {3'h0, q}, s);
  endtask
  task automatic wait_frames(input int k);
    int n;
    n = 0;
    while (u_uart_line_peer.rx_q.size() < k && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000)
    begin
      failures++;
      report_and_stop();
    end
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(OFS_CONTROL, 8'h00, "control");
    rdc(OFS_STATUS, 8'h00, "status");
    rdc(5'h1c, 8'h00, "unmapped");
    $display("Test reset done");
    for (int p = 1; p >= 0; p--)
    begin
      bit_clks = p ? 16 : 32;
      w8(OFS_POWER, {p[0], 7'h0});
      w8(OFS_CONTROL, 8'h88);
      u_uart_line_peer.rx_q.delete();
      w8(OFS_DATA, 8'ha5 + 8'(p));
      w8(OFS_DATA, 8'h00);
      wait_frames(1);
      repeat (14 * bit_clks) @(posedge clk);
      chk({2'b11, 8'ha5 + 8'(p), 1'b0}, u_uart_line_peer.rx_q[0], "frame9");
      chk(11'd1, 11'(u_uart_line_peer.rx_q.size()), "frames");
    end
    $display("Test fixed rate done");
    bit_clks = 16;
    w8(OFS_POWER, 8'h80);
    w8(OFS_CONTROL, 8'h90);
    repeat (10) @(posedge clk);
    u_uart_line_peer.send(11, {2'b10, 8'h3c, 1'b0});
    repeat (20) @(posedge clk);
    rdc(OFS_DATA, 8'h3c, "rx9 data");
    rdc(OFS_CONTROL, 8'h91, "rx9 flags");
    $display("Test receive9 done");
    bit_clks = 32;
    nbits = 10;
    w8(OFS_BRG_LO, 8'h01);
    w8(OFS_BRG_HI, 8'h00);
    w8(OFS_BRG_SEL, 8'h01);
    w8(OFS_POWER, 8'h00);
    w8(OFS_CONTROL, 8'h50);
    u_uart_line_peer.rx_q.delete();
    w8(OFS_DATA, 8'h5a);
    wait_frames(1);
    chk({2'b01, 8'h5a, 1'b0}, u_uart_line_peer.rx_q[0], "frame8");
    u_uart_line_peer.send(10, {2'b01, 8'hc3, 1'b0});
    repeat (20) @(posedge clk);
    rdc(OFS_DATA, 8'hc3, "rx8 data");
    rdc(OFS_CONTROL, 8'h57, "rx8 flags");
    w8(OFS_CONTROL, 8'h50);
    u_uart_line_peer.send(10, {2'b00, 8'h11, 1'b0});
    repeat (20) @(posedge clk);
    rdc(OFS_STATUS, 8'h08, "frame error");
    w8(OFS_POWER, 8'h40);
    rdc(OFS_CONTROL, 8'hd1, "error view");
    w8(OFS_POWER, 8'h00);
    $display("Test brg done");
    w8(OFS_CONTROL, 8'h50);
    w8(OFS_STATUS, 8'h40);
    u_uart_line_peer.send(11, 11'h000);
    @(posedge clk);
    u_uart_line_peer.send(11, 11'h000);
    repeat (20) @(posedge clk);
    rdc(OFS_STATUS, 8'h4c, "break");
    chk(11'd1, {10'h0, boot_seen}, "boot request");
    $display("Test break done");
    bit_clks = 16;
    nbits = 11;
    w8(OFS_POWER, 8'h80);
    w8(OFS_STATUS, 8'h80);
    w8(OFS_CONTROL, 8'h88);
    u_uart_line_peer.rx_q.delete();
    u_uart_line_peer.t_q.delete();
    w8(OFS_DATA, 8'h81);
    rdc(OFS_CONTROL, 8'h8a, "ti on load");
    w8(OFS_CONTROL, 8'h80);
    w8(OFS_DATA, 8'h7e);
    w8(OFS_CONTROL, 8'h88);
    wait_frames(2);
    chk({2'b11, 8'h81, 1'b0}, u_uart_line_peer.rx_q[0], "first");
    chk({2'b10, 8'h7e, 1'b0}, u_uart_line_peer.rx_q[1], "second");
    chk(11'd176, 11'((u_uart_line_peer.t_q[1] - u_uart_line_peer.t_q[0]) / 10), "gap");
    $display("Test double buffer done");
    repeat (20) @(posedge clk);
    w8(OFS_STATUS, 8'h00);
    w8(OFS_CONTROL, 8'h00);
    w8(OFS_DATA, 8'h96);
    repeat (10) @(posedge clk);
    chk(11'd0, {10'h0, rxd_oe_n}, "shift drive");
    repeat (138) @(posedge clk);
    chk({3'h0, 8'h96}, {3'h0, shreg}, "shift data");
    chk(11'd1, {10'h0, ti}, "ti pin");
    w8(OFS_CONTROL, 8'h10);
    u_uart_line_peer.send(8, {3'h0, 8'h6c});
    repeat (10) @(posedge clk);
    rdc(OFS_DATA, 8'h6c, "shift rx");
    chk(11'd1, {10'h0, ri}, "ri pin");
    $display("Test shift done");
    repeat (200) @(posedge clk);
    bit_clks = 32;
    t1 <= 1'b1;
    w8(OFS_BRG_SEL, 8'h00);
    w8(OFS_POWER, 8'h80);
    w8(OFS_CONTROL, 8'hc8);
    u_uart_line_peer.rx_q.delete();
    w8(OFS_DATA, 8'h3e);
    wait_frames(1);
    chk({2'b11, 8'h3e, 1'b0}, u_uart_line_peer.rx_q[0], "frame timer");
    $display("Test timer done");
    report_and_stop();
  end
endmodule
